// File: logic/spt_ssi_tx.sv
`timescale 1ns/100ps

module spt_ssi_tx
	import spt_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `SPT_TIMEOUT_CYCLES,
	parameter int UPDATE_CYCLES  = `SPT_UPDATE_CYCLES
) (
	// Core clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     srst,
	// Serial link
	input  wire logic                     ssi_clk,
	output logic                          ssi_data,
	// Position engine
	input  wire logic [`SPT_POS_BITS-1:0] pos_word,
	input  wire logic                     pos_invalid,
	input  wire logic                     near_limit,
	output logic                          upd_tick,
	// Status
	output logic                          frame_busy,
	output spt_pos_t                      sent_pos,
	output spt_event_t                    frame_ev
);

	localparam int CNT_MAX = (1 << `SPT_CNT_BITS) - 1;

	generate
		if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > CNT_MAX) begin : g_to_chk
			$error("TIMEOUT_CYCLES out of range");
		end
		if (UPDATE_CYCLES < 2 || UPDATE_CYCLES > CNT_MAX) begin : g_up_chk
			$error("UPDATE_CYCLES out of range");
		end
	endgenerate

	localparam logic [`SPT_CNT_BITS-1:0] TO_LIMIT =
		`SPT_CNT_BITS'(TIMEOUT_CYCLES);
	localparam logic [`SPT_CNT_BITS-1:0] UPD_LAST =
		`SPT_CNT_BITS'(UPDATE_CYCLES - 1);
	localparam logic [4:0] LAST_IDX = 5'(`SPT_FRAME_BITS);

	localparam spt_core_t CORE_RESET = '{
		link_clr:  1'h1,
		rise_sync: 2'h0,
		fall_sync: 2'h0,
		rise_seen: 1'h0,
		fall_seen: 1'h0,
		upd_cnt:   '0,
		take:      1'h0,
		latest:    '0,
		sent_pos:  '0,
		state:     spt_st_ready,
		frame:     '0,
		bit_idx:   5'h00,
		idle_cnt:  TO_LIMIT,
		data:      `SPT_DATA_IDLE,
		busy:      1'h0,
		ev:        '0
	};

	// Builds the whole frame: body first, then the inverted check word.
	function automatic logic [`SPT_FRAME_BITS-1:0] build_frame(
		input spt_pos_t p
	);
		logic [`SPT_BODY_BITS-1:0] body;
		logic [`SPT_CRC_BITS-1:0]  crc;
		logic                      fb;
		body = {p.valid, p.pos, p.margin_ok};
		crc = `SPT_CRC_INIT;
		for (int i = `SPT_BODY_BITS - 1; i >= 0; i--) begin
			fb = crc[`SPT_CRC_BITS-1] ^ body[i];
			crc = {crc[`SPT_CRC_BITS-2:0], 1'h0};
			if (fb) begin
				crc = crc ^ `SPT_CRC_POLY;
			end
		end
		return {body, ~crc};
	endfunction

	spt_core_t st;
	spt_core_t next_st;
	logic      rise_tog;
	logic      fall_tog;
	logic      rise_ev;
	logic      fall_ev;
	logic      timed_out;

	spt_link_edges u_edges (
		.ssi_clk  (ssi_clk),
		.link_clr (st.link_clr),
		.rise_tog (rise_tog),
		.fall_tog (fall_tog)
	);

	always_comb begin
		next_st = st;
		next_st.link_clr = 1'h0;
		next_st.ev = '0;
		next_st.take = 1'h0;

		// Edge flags cross as toggles through two flip-flops.
		next_st.rise_sync = {st.rise_sync[0], rise_tog};
		next_st.fall_sync = {st.fall_sync[0], fall_tog};
		rise_ev = st.rise_sync[1] ^ st.rise_seen;
		fall_ev = st.fall_sync[1] ^ st.fall_seen;
		next_st.rise_seen = st.rise_sync[1];
		next_st.fall_seen = st.fall_sync[1];

		if (st.upd_cnt == UPD_LAST) begin
			next_st.upd_cnt = '0;
			next_st.take = 1'h1;
			next_st.latest.valid = ~pos_invalid;
			next_st.latest.margin_ok = ~pos_invalid & ~near_limit;
			next_st.latest.pos = pos_word;
		end else begin
			next_st.upd_cnt = st.upd_cnt + 1'h1;
		end

		timed_out = (st.idle_cnt == TO_LIMIT);
		if (rise_ev || fall_ev) begin
			next_st.idle_cnt = '0;
		end else if (!timed_out) begin
			next_st.idle_cnt = st.idle_cnt + 1'h1;
		end

		case (st.state)
			spt_st_ready: begin
				next_st.data = `SPT_DATA_IDLE;
				next_st.busy = 1'h0;
				if (fall_ev) begin
					next_st.frame = build_frame(st.latest);
					next_st.sent_pos = st.latest;
					next_st.bit_idx = 5'h00;
					next_st.state = spt_st_shift;
					next_st.busy = 1'h1;
					next_st.ev.start = 1'h1;
				end
			end
			spt_st_shift: begin
				if (timed_out) begin
					next_st.data = `SPT_DATA_IDLE;
					next_st.state = spt_st_ready;
					next_st.busy = 1'h0;
					next_st.ev.abort = 1'h1;
				end else if (rise_ev) begin
					if (st.bit_idx == LAST_IDX) begin
						next_st.data = `SPT_DATA_TAIL;
						next_st.state = spt_st_tail;
						next_st.ev.sent = 1'h1;
					end else begin
						next_st.data =
							st.frame[LAST_IDX - 5'h01 - st.bit_idx];
						next_st.bit_idx = st.bit_idx + 5'h01;
					end
				end
			end
			spt_st_tail: begin
				next_st.data = `SPT_DATA_TAIL;
				if (timed_out) begin
					next_st.data = `SPT_DATA_IDLE;
					next_st.state = spt_st_ready;
					next_st.busy = 1'h0;
				end else if (fall_ev) begin
					next_st.bit_idx = 5'h00;
					next_st.state = spt_st_shift;
					next_st.ev.repeat_start = 1'h1;
				end
			end
			default: begin
				next_st.data = `SPT_DATA_IDLE;
				next_st.state = spt_st_ready;
				next_st.busy = 1'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= CORE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign ssi_data = st.data;
	assign upd_tick = st.take;
	assign frame_busy = st.busy;
	assign sent_pos = st.sent_pos;
	assign frame_ev = st.ev;

endmodule

// File: logic/spt_defines.svh
`ifndef SPT_DEFINES_SVH
`define SPT_DEFINES_SVH

// Frame layout, most significant bit is sent first.
`define SPT_FRAME_BITS      31
`define SPT_BODY_BITS       25
`define SPT_VALID_BIT       30
`define SPT_POS_MSB         29
`define SPT_POS_LSB         7
`define SPT_POS_BITS        23
`define SPT_MARGIN_BIT      6
`define SPT_CRC_BITS        6

// Check word: generator x^6 + x + 1, start value zero.
`define SPT_CRC_POLY        6'h03
`define SPT_CRC_INIT        6'h00

// Line levels.
`define SPT_DATA_IDLE       1'h1
`define SPT_DATA_TAIL       1'h0

// Timing.
`define SPT_CORE_PERIOD_NS  100
`define SPT_CORE_CLK_HZ     10000000
`define SPT_TIMEOUT_US      20
`define SPT_TIMEOUT_CYCLES  ((`SPT_TIMEOUT_US * 1000 + `SPT_CORE_PERIOD_NS - 1) / `SPT_CORE_PERIOD_NS)
`define SPT_REFRESH_KHZ     30
`define SPT_UPDATE_CYCLES   (`SPT_CORE_CLK_HZ / (`SPT_REFRESH_KHZ * 1000))

// Counter width for the time-out and update timers.
`define SPT_CNT_BITS        16

`endif

// File: logic/spt_pkg.sv
`include "spt_defines.svh"

package spt_pkg;

	typedef enum logic [1:0] {
		spt_st_ready,
		spt_st_shift,
		spt_st_tail
	} spt_state_t;

	typedef struct packed {
		logic                        valid;
		logic                        margin_ok;
		logic [`SPT_POS_BITS-1:0]    pos;
	} spt_pos_t;

	typedef struct packed {
		logic                        start;
		logic                        repeat_start;
		logic                        sent;
		logic                        abort;
	} spt_event_t;

	typedef struct packed {
		logic                        link_clr;
		logic [1:0]                  rise_sync;
		logic [1:0]                  fall_sync;
		logic                        rise_seen;
		logic                        fall_seen;
		logic [`SPT_CNT_BITS-1:0]    upd_cnt;
		logic                        take;
		spt_pos_t                    latest;
		spt_pos_t                    sent_pos;
		spt_state_t                  state;
		logic [`SPT_FRAME_BITS-1:0]  frame;
		logic [4:0]                  bit_idx;
		logic [`SPT_CNT_BITS-1:0]    idle_cnt;
		logic                        data;
		logic                        busy;
		spt_event_t                  ev;
	} spt_core_t;

endpackage

// File: logic/spt_link_edges.sv
`timescale 1ns/100ps

module spt_link_edges
	import spt_pkg::*;
(
	// Serial clock from the controller
	input  wire logic ssi_clk,
	// Clear from the core domain, released while the clock idles
	input  wire logic link_clr,
	// Edge toggles toward the core domain
	output logic      rise_tog,
	output logic      fall_tog
);

	// Each edge flips its own flag, so the core sees every edge once.
	always_ff @(posedge ssi_clk or posedge link_clr) begin
		if (link_clr) begin
			rise_tog <= 1'h0;
		end else begin
			rise_tog <= ~rise_tog;
		end
	end

	always_ff @(negedge ssi_clk or posedge link_clr) begin
		if (link_clr) begin
			fall_tog <= 1'h0;
		end else begin
			fall_tog <= ~fall_tog;
		end
	end

endmodule

// File: verif/spt_ssi_tx_checker.sv
`timescale 1ns/100ps
module spt_ssi_tx_checker
	import spt_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 40,
	parameter int UPDATE_CYCLES  = 20
) (
	// Clocks and reset
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       ssi_clk,
	// Watched outputs
	input wire logic       ssi_data,
	input wire logic       upd_tick,
	input wire logic       frame_busy,
	input wire spt_pos_t   sent_pos,
	input wire spt_event_t frame_ev
);
	localparam int QUIET_MAX = TIMEOUT_CYCLES + 6;
	logic [15:0] quiet_cnt;
	logic        clk_q;
	logic [15:0] tick_gap;
	logic        tick_seen;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Counts core cycles since the serial clock last moved.
	always_ff @(posedge core_clk) begin
		clk_q <= ssi_clk;
		if (srst || clk_q != ssi_clk)
			quiet_cnt <= 16'h0000;
		else if (quiet_cnt != 16'hffff)
			quiet_cnt <= quiet_cnt + 16'h0001;
	end
	// Counts core cycles since the last refresh pulse.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tick_gap <= 16'h0000;
			tick_seen <= 1'h0;
		end else if (upd_tick) begin
			tick_gap <= 16'h0001;
			tick_seen <= 1'h1;
		end else if (tick_gap != 16'hffff) begin
			tick_gap <= tick_gap + 16'h0001;
		end
	end
	idle_high_a: assert property (!frame_busy |-> ssi_data)
		else $error("data low while idle");
	start_busy_a: assert property (frame_ev.start |-> frame_busy)
		else $error("start without busy");
	busy_cause_a: assert property ($rose(frame_busy) |-> frame_ev.start)
		else $error("busy without start");
	tail_low_a: assert property (frame_ev.sent |-> ##[0:1] !ssi_data)
		else $error("tail not low");
	abort_high_a: assert property (frame_ev.abort |-> ##[0:1] ssi_data)
		else $error("abort not high");
	pos_hold_a: assert property (frame_busy && $past(frame_busy)
		&& !frame_ev.start |-> $stable(sent_pos))
		else $error("position changed in frame");
	tick_period_a: assert property (upd_tick && tick_seen
		|-> tick_gap == UPDATE_CYCLES)
		else $error("update period wrong");
	flag_order_a: assert property (sent_pos.margin_ok |-> sent_pos.valid)
		else $error("margin set on invalid");
	quiet_ready_a: assert property (quiet_cnt > QUIET_MAX |-> !frame_busy)
		else $error("time-out missed");
	cover property (frame_ev.start);
	cover property (frame_ev.repeat_start);
	cover property (frame_ev.abort);
endmodule
bind spt_ssi_tx spt_ssi_tx_checker #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.UPDATE_CYCLES(UPDATE_CYCLES)
) i_chk (.core_clk, .srst, .ssi_clk, .ssi_data, .upd_tick, .frame_busy,
	.sent_pos, .frame_ev);

// File: verif/spt_ctrl_model.sv
`timescale 1ns/100ps
module spt_ctrl_model (
	// Serial link
	output logic      ssi_clk,
	input  wire logic ssi_data
);
	initial ssi_clk = 1'h1;
	task automatic read(input int n, output logic [31:0] q);
		q = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			ssi_clk = 1'h0;
			#504;
			ssi_clk = 1'h1;
			#504;
			q = {q[30:0], ssi_data};
		end
	endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import spt_pkg::*;
;
	typedef struct packed {
		logic [22:0] p;
		logic        inv;
		logic        near;
		logic        v;
		logic        m;
	} spt_row_t;
	logic        core_clk;
	logic        srst;
	logic        ssi_clk;
	logic        ssi_data;
	logic [22:0] pos_word;
	logic        pos_invalid;
	logic        near_limit;
	logic        upd_tick;
	logic        frame_busy;
	spt_pos_t    sent_pos;
	spt_event_t  frame_ev;
	logic [31:0] q;
	logic [24:0] b;
	int          error_cnt;
	int          num_checks;
	int          cyc;
	spt_row_t    rows [4] = '{'{23'h12_3456, 1'h0, 1'h0, 1'h1, 1'h1},
		'{23'h7f_ffff, 1'h0, 1'h1, 1'h1, 1'h0},
		'{23'h00_0001, 1'h1, 1'h0, 1'h0, 1'h0},
		'{23'h2a_aaaa, 1'h1, 1'h1, 1'h0, 1'h0}};
	spt_ssi_tx #(.TIMEOUT_CYCLES(40), .UPDATE_CYCLES(20)) i_dut (
		.core_clk, .srst, .ssi_clk, .ssi_data, .pos_word, .pos_invalid,
		.near_limit, .upd_tick, .frame_busy, .sent_pos, .frame_ev);
	spt_ctrl_model i_ctrl (.ssi_clk, .ssi_data);
	function automatic logic [30:0] frm(logic [24:0] d);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 24; i >= 0; i--)
			c = {c[4:0], 1'h0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
		return {d, ~c};
	endfunction
	task automatic check(string n, logic [30:0] seen, logic [30:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic set_in(int i);
		@(posedge core_clk);
		pos_word <= rows[i].p;
		pos_invalid <= rows[i].inv;
		near_limit <= rows[i].near;
		b = {rows[i].v, rows[i].p, rows[i].m};
		repeat (30) @(posedge core_clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		srst = 1'h1;
		pos_word = 23'h00_0000;
		pos_invalid = 1'h0;
		near_limit = 1'h0;
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		check("idle", ssi_data, 1'h1);
		@(posedge core_clk);
		srst <= 1'h0;
		foreach (rows[i]) begin
			set_in(i);
			i_ctrl.read(32, q);
			check("frame", q[31:1], frm(b));
			check("tail", q[0], 1'h0);
			check("pos", sent_pos, {rows[i].v, rows[i].m, rows[i].p});
			repeat (60) @(posedge core_clk);
			check("ready", {ssi_data, frame_busy}, 2'h2);
		end
		set_in(0);
		i_ctrl.read(32, q);
		set_in(1);
		i_ctrl.read(32, q);
		check("repeat", q[31:1], frm({1'h1, rows[0].p, 1'h1}));
		check("held", sent_pos, {1'h1, 1'h1, rows[0].p});
		repeat (60) @(posedge core_clk);
		i_ctrl.read(8, q);
		check("part", q[7:0], frm(b) >> 23);
		repeat (60) @(posedge core_clk);
		check("abort", ssi_data, 1'h1);
		set_in(2);
		i_ctrl.read(32, q);
		check("fresh", q[31:1], frm(b));
		repeat (60) @(posedge core_clk);
		tally_and_finish();
	end
endmodule
